// file: design/mio_pkg.sv
// Behaviour
// - Pin drives when its direction bit or logic-array enable term is 1.
// - With no active enable term, the direction bit alone sets pin direction.
// - Port D direction keeps only its three low bits; upper bits ignored.
// - Drive-select 1 on open-drain pin gives open drain; reset gives push-pull.
// - Drive-select 1 on slew pin gives fast slew; reset gives standard slew.
// - Port B drive bits 7..4 select open drain, bits 3..0 fast slew.
// - Port C drive bits 7..0 all select open drain; no slew control.
// - Port D drive bits 2..0 select fast slew; bits 7..3 do nothing.
// - Port B carries first or shared macrocell group; port C only shared.
// - Ports B, C enter logic array via input macrocells; port D directly.
// - Port C test pins can be handed to the in-system programming port.
// - Port D bit 1 can be the external clock for output macrocells.
// - Port D bit 2 high as chip-select input puts registers in standby.
// - Three port D chip-selects, one product term each, polarity selectable.
// - Chip-select pin enabled by its enable term or direction bit.
// - Extra chip-selects may leave on ports B or C from macrocells.
// - All direction bits reset to 0 so every pin starts as input.
// - Data-out bit sets pin only when the logic array does not drive it.
// - Data-in read returns the actual level of each pin, bit n pin n.
package mio_pkg;
  localparam int PORT_B_WIDTH = 8;
  localparam int PORT_C_WIDTH = 8;
  localparam int PORT_D_WIDTH = 3;
  localparam int PIN_COUNT = PORT_B_WIDTH + PORT_C_WIDTH + PORT_D_WIDTH;
  localparam int SEL_WIDTH = 4;

  // Register indices on the host register port
  localparam logic [3:0] REG_DATAIN_B = 4'h0;
  localparam logic [3:0] REG_DATAOUT_B = 4'h1;
  localparam logic [3:0] REG_DIR_B = 4'h2;
  localparam logic [3:0] REG_DRV_B = 4'h3;
  localparam logic [3:0] REG_DATAIN_C = 4'h4;
  localparam logic [3:0] REG_DATAOUT_C = 4'h5;
  localparam logic [3:0] REG_DIR_C = 4'h6;
  localparam logic [3:0] REG_DRV_C = 4'h7;
  localparam logic [3:0] REG_DATAIN_D = 4'h8;
  localparam logic [3:0] REG_DATAOUT_D = 4'h9;
  localparam logic [3:0] REG_DIR_D = 4'hA;
  localparam logic [3:0] REG_DRV_D = 4'hB;

  // Field positions inside the port B drive-select register
  localparam int DRV_B_OD_LSB = 4;
  localparam int DRV_B_SLEW_MSB = 3;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] REG_D_RESET = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic [SEL_WIDTH-1:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } mio_bus_s;

  typedef struct packed {
    logic [7:0] portBGroupShared;
    logic [7:0] arrayDriveB;
    logic [7:0] arrayDriveC;
    logic [7:0] imcRegisteredB;
    logic [7:0] imcRegisteredC;
    logic [2:0] ecsEnable;
    logic [2:0] ecsActiveHigh;
    logic ispEnable;
    logic extClockEnable;
    logic chipSelInEnable;
  } mio_cfg_s;

  typedef struct packed {
    logic [7:0] dataOutB;
    logic [7:0] dataOutC;
    logic [2:0] dataOutD;
    logic [7:0] dirB;
    logic [7:0] dirC;
    logic [2:0] dirD;
    logic [7:0] drvB;
    logic [7:0] drvC;
    logic [2:0] drvD;
    logic [7:0] imcB;
    logic [7:0] imcC;
    logic [2:0] arrayInD;
    logic [7:0] rdData;
    logic [PIN_COUNT-1:0] pinOut;
    logic [PIN_COUNT-1:0] pinOe;
    logic [3:0] slewFastB;
    logic [2:0] slewFastD;
    logic logicClock;
    logic memStandby;
  } mio_state_s;
endpackage : mio_pkg

// file: design/mio_pin_ctrl.sv
`timescale 1ns/1ps
module mio_pin_ctrl (
  input wire logic dirBit,
  input wire logic oeTerm,
  input wire logic arrayDrive,
  input wire logic arrayData,
  input wire logic dataOutBit,
  input wire logic openDrain,
  output logic drvOe,
  output logic drvLevel
);
  logic enable;
  logic level;

  always_comb begin
    enable = dirBit | oeTerm;
    level = arrayDrive ? arrayData : dataOutBit;
    if (openDrain) begin
      // Only a low is ever driven; the pull-up supplies the high
      drvOe = enable & ~level;
      drvLevel = 1'b0;
    end else begin
      drvOe = enable;
      drvLevel = level;
    end
  end
endmodule : mio_pin_ctrl

// file: design/mio_port_ctrl.sv
`timescale 1ns/1ps
module mio_port_ctrl #(
  parameter logic [7:0] ISP_PIN_MASK = 8'h0F
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire mio_pkg::mio_bus_s bus,
  output logic [7:0] rdData,
  input wire mio_pkg::mio_cfg_s cfg,
  input wire logic [7:0] macrocellGroupFirst,
  input wire logic [7:0] macrocellGroupShared,
  input wire logic [7:0] oeTermB,
  input wire logic [7:0] oeTermC,
  input wire logic [2:0] oeTermD,
  input wire logic [2:0] ecsTerm,
  input wire logic [7:0] imcClockTermB,
  input wire logic [7:0] imcClockTermC,
  input wire logic [7:0] ispOut,
  input wire logic [7:0] ispOe,
  input wire logic [7:0] pinInB,
  input wire logic [7:0] pinInC,
  input wire logic [2:0] pinInD,
  output logic [7:0] pinOutB,
  output logic [7:0] pinOeB,
  output logic [7:0] pinOutC,
  output logic [7:0] pinOeC,
  output logic [2:0] pinOutD,
  output logic [2:0] pinOeD,
  output logic [3:0] slewFastB,
  output logic [2:0] slewFastD,
  output logic [7:0] inputMacrocellB,
  output logic [7:0] inputMacrocellC,
  output logic [2:0] arrayInD,
  output logic logicClock,
  output logic memStandby
);
  import mio_pkg::*;

  mio_state_s st;
  mio_state_s next_st;

  logic busBlocked;
  logic busWrite;
  logic busRead;
  logic [PIN_COUNT-1:0] dirVec;
  logic [PIN_COUNT-1:0] oeVec;
  logic [PIN_COUNT-1:0] driveVec;
  logic [PIN_COUNT-1:0] arrayDataVec;
  logic [PIN_COUNT-1:0] dataOutVec;
  logic [PIN_COUNT-1:0] odVec;
  logic [PIN_COUNT-1:0] drvOeVec;
  logic [PIN_COUNT-1:0] drvLevelVec;
  logic [7:0] bSource;
  logic [2:0] ecsLevel;

  // A deselected chip-select input freezes the register block only
  assign busBlocked = cfg.chipSelInEnable & pinInD[2];
  assign busWrite = bus.wr & ~busBlocked;
  assign busRead = bus.rd & ~busBlocked;

  always_comb begin
    for (int i = 0; i < PORT_B_WIDTH; i++) begin
      bSource[i] = cfg.portBGroupShared[i] ? macrocellGroupShared[i]
                                           : macrocellGroupFirst[i];
    end
  end

  // Product term true gives the configured active level
  assign ecsLevel = ecsTerm ~^ cfg.ecsActiveHigh;

  assign dirVec = {st.dirD, st.dirC, st.dirB};
  assign oeVec = {oeTermD, oeTermC, oeTermB};
  // Macrocells may carry chip-select equations to ports B and C
  assign driveVec = {cfg.ecsEnable, cfg.arrayDriveC,
                     cfg.arrayDriveB};
  assign arrayDataVec = {ecsLevel, macrocellGroupShared, bSource};
  assign dataOutVec = {st.dataOutD, st.dataOutC, st.dataOutB};
  assign odVec = {3'h0, st.drvC,
                  st.drvB[7:DRV_B_OD_LSB], 4'h0};

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    mio_pin_ctrl u_pin (
      .dirBit(dirVec[p]),
      .oeTerm(oeVec[p]),
      .arrayDrive(driveVec[p]),
      .arrayData(arrayDataVec[p]),
      .dataOutBit(dataOutVec[p]),
      .openDrain(odVec[p]),
      .drvOe(drvOeVec[p]),
      .drvLevel(drvLevelVec[p])
    );
  end

  always_comb begin
    next_st = st;
    if (busWrite) begin
      case (bus.sel)
        REG_DATAOUT_B: next_st.dataOutB = bus.wdata;
        REG_DIR_B: next_st.dirB = bus.wdata;
        REG_DRV_B: next_st.drvB = bus.wdata;
        REG_DATAOUT_C: next_st.dataOutC = bus.wdata;
        REG_DIR_C: next_st.dirC = bus.wdata;
        REG_DRV_C: next_st.drvC = bus.wdata;
        REG_DATAOUT_D: next_st.dataOutD = bus.wdata[PORT_D_WIDTH-1:0];
        REG_DIR_D: next_st.dirD = bus.wdata[PORT_D_WIDTH-1:0];
        REG_DRV_D: next_st.drvD = bus.wdata[PORT_D_WIDTH-1:0];
        default: ;
      endcase
    end

    // Read data holds for one cycle after the read strobe
    next_st.rdData = UNMAPPED_READ;
    if (busRead) begin
      case (bus.sel)
        REG_DATAIN_B: next_st.rdData = pinInB;
        REG_DATAOUT_B: next_st.rdData = st.dataOutB;
        REG_DIR_B: next_st.rdData = st.dirB;
        REG_DRV_B: next_st.rdData = st.drvB;
        REG_DATAIN_C: next_st.rdData = pinInC;
        REG_DATAOUT_C: next_st.rdData = st.dataOutC;
        REG_DIR_C: next_st.rdData = st.dirC;
        REG_DRV_C: next_st.rdData = st.drvC;
        REG_DATAIN_D: next_st.rdData = {5'h00, pinInD};
        REG_DATAOUT_D: next_st.rdData = {5'h00, st.dataOutD};
        REG_DIR_D: next_st.rdData = {5'h00, st.dirD};
        REG_DRV_D: next_st.rdData = {5'h00, st.drvD};
        default: next_st.rdData = UNMAPPED_READ;
      endcase
    end

    next_st.pinOut = drvLevelVec;
    next_st.pinOe = drvOeVec;
    // Programming port takes its pins over whatever else is configured
    if (cfg.ispEnable) begin
      for (int i = 0; i < PORT_C_WIDTH; i++) begin
        if (ISP_PIN_MASK[i]) begin
          next_st.pinOut[PORT_B_WIDTH + i] = ispOut[i];
          next_st.pinOe[PORT_B_WIDTH + i] = ispOe[i];
        end
      end
    end
    // Dedicated input functions must never be driven from inside
    if (cfg.extClockEnable) begin
      next_st.pinOe[PORT_B_WIDTH + PORT_C_WIDTH + 1] = 1'b0;
    end
    if (cfg.chipSelInEnable) begin
      next_st.pinOe[PORT_B_WIDTH + PORT_C_WIDTH + 2] = 1'b0;
    end

    next_st.slewFastB = st.drvB[DRV_B_SLEW_MSB:0];
    next_st.slewFastD = st.drvD;

    for (int i = 0; i < PORT_B_WIDTH; i++) begin
      if (!cfg.imcRegisteredB[i] || imcClockTermB[i]) begin
        next_st.imcB[i] = pinInB[i];
      end
    end
    for (int i = 0; i < PORT_C_WIDTH; i++) begin
      if (!cfg.imcRegisteredC[i] || imcClockTermC[i]) begin
        next_st.imcC[i] = pinInC[i];
      end
    end
    next_st.arrayInD = pinInD;
    next_st.logicClock = cfg.extClockEnable & pinInD[1];
    next_st.memStandby = busBlocked;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.dataOutB <= REG_RESET;
      st.dataOutC <= REG_RESET;
      st.dataOutD <= REG_D_RESET;
      st.dirB <= REG_RESET;
      st.dirC <= REG_RESET;
      st.dirD <= REG_D_RESET;
      st.drvB <= REG_RESET;
      st.drvC <= REG_RESET;
      st.drvD <= REG_D_RESET;
      st.imcB <= REG_RESET;
      st.imcC <= REG_RESET;
      st.arrayInD <= REG_D_RESET;
      st.rdData <= REG_RESET;
      st.pinOut <= '0;
      st.pinOe <= '0;
      st.slewFastB <= 4'h0;
      st.slewFastD <= 3'h0;
      st.logicClock <= 1'b0;
      st.memStandby <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;
  assign pinOutB = st.pinOut[PORT_B_WIDTH-1:0];
  assign pinOeB = st.pinOe[PORT_B_WIDTH-1:0];
  assign pinOutC = st.pinOut[PORT_B_WIDTH+PORT_C_WIDTH-1:PORT_B_WIDTH];
  assign pinOeC = st.pinOe[PORT_B_WIDTH+PORT_C_WIDTH-1:PORT_B_WIDTH];
  assign pinOutD = st.pinOut[PIN_COUNT-1:PORT_B_WIDTH+PORT_C_WIDTH];
  assign pinOeD = st.pinOe[PIN_COUNT-1:PORT_B_WIDTH+PORT_C_WIDTH];
  assign slewFastB = st.slewFastB;
  assign slewFastD = st.slewFastD;
  assign inputMacrocellB = st.imcB;
  assign inputMacrocellC = st.imcC;
  assign arrayInD = st.arrayInD;
  assign logicClock = st.logicClock;
  assign memStandby = st.memStandby;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Low nibble of port B has no open-drain option, so enables are plain
  property p_pin_enable_or;
    ##1 pinOeB[3:0] == ($past(st.dirB[3:0]) | $past(oeTermB[3:0]));
  endproperty
  a_pin_enable_or: assert property (p_pin_enable_or)
    else $error("port B enable is not direction OR enable term");

  property p_dir_alone;
    (oeTermB[3:0] == 4'h0) |=> pinOeB[3:0] == $past(st.dirB[3:0]);
  endproperty
  a_dir_alone: assert property (p_dir_alone)
    else $error("direction bit does not alone set port B enable");

  sequence s_write_dir_d;
    bus.wr && !busBlocked && bus.sel == REG_DIR_D && bus.wdata == 8'hFF;
  endsequence
  sequence s_read_dir_d;
    bus.rd && !busBlocked && bus.sel == REG_DIR_D;
  endsequence
  property p_dir_d_three_bits;
    // The host leaves exactly one idle cycle between the write and the read back
    s_write_dir_d ##1 !bus.wr ##1 (s_read_dir_d and !bus.wr)
      |=> rdData == 8'h07;
  endproperty
  a_dir_d_three_bits: assert property (p_dir_d_three_bits)
    else $error("port D direction read shows bits above three");

  property p_open_drain_release;
    (st.drvC[0] && next_st.pinOut[PORT_B_WIDTH] == 1'b0 && !cfg.ispEnable
     && cfg.arrayDriveC[0] == 1'b0 && st.dataOutC[0])
      |=> pinOeC[0] == 1'b0;
  endproperty
  a_open_drain_release: assert property (p_open_drain_release)
    else $error("open-drain pin driven while its value is high");

  property p_open_drain_low;
    (st.drvB[7] && !st.dataOutB[7] && !cfg.arrayDriveB[7] && st.dirB[7])
      |=> pinOeB[7] && !pinOutB[7];
  endproperty
  a_open_drain_low: assert property (p_open_drain_low)
    else $error("open-drain pin not pulled low for a zero");

  property p_slew_b;
    ##1 slewFastB == $past(st.drvB[3:0]);
  endproperty
  a_slew_b: assert property (p_slew_b)
    else $error("port B slew does not follow drive bits 3 to 0");

  property p_slew_d;
    ##1 slewFastD == $past(st.drvD);
  endproperty
  a_slew_d: assert property (p_slew_d)
    else $error("port D slew does not follow drive bits 2 to 0");

  property p_standby_blocks;
    (cfg.chipSelInEnable && pinInD[2] && bus.wr)
      |=> $stable(st.dirB) ##0 memStandby;
  endproperty
  a_standby_blocks: assert property (p_standby_blocks)
    else $error("register written while chip-select input is high");

  property p_reset_inputs;
    $rose(reset_n) |-> pinOeB == 8'h00 && pinOeC == 8'h00 && st.dirD == 3'h0;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pins not inputs right after reset");

  property p_data_in;
    (bus.rd && !busBlocked && bus.sel == REG_DATAIN_B)
      |=> rdData == $past(pinInB);
  endproperty
  a_data_in: assert property (p_data_in)
    else $error("data-in read differs from pin levels");

  property p_ecs_level;
    cfg.ecsEnable[0] |=> pinOutD[0] == ($past(ecsTerm[0]) ~^
                                        $past(cfg.ecsActiveHigh[0]));
  endproperty
  a_ecs_level: assert property (p_ecs_level)
    else $error("chip-select output level wrong for its polarity");

  property p_array_override;
    (cfg.arrayDriveC[1] && !st.drvC[1] && !cfg.ispEnable)
      |=> pinOutC[1] == $past(macrocellGroupShared[1]);
  endproperty
  a_array_override: assert property (p_array_override)
    else $error("data-out overrode a logic-array driven pin");
endmodule : mio_port_ctrl

// file: tb/mio_pin_model.sv
`timescale 1ns/1ps
module mio_pin_model (
  input wire logic [7:0] pinOutB,
  input wire logic [7:0] pinOeB,
  input wire logic [7:0] pinOutC,
  input wire logic [7:0] pinOeC,
  input wire logic [2:0] pinOutD,
  input wire logic [2:0] pinOeD,
  input wire logic [7:0] extB,
  input wire logic [7:0] extOeB,
  input wire logic [7:0] extC,
  input wire logic [7:0] extOeC,
  input wire logic [2:0] extD,
  input wire logic [2:0] extOeD,
  output logic [7:0] pinInB,
  output logic [7:0] pinInC,
  output logic [2:0] pinInD
);
  // Every pin has a board pull-up, so a released open-drain pin reads 1
  function automatic logic [7:0] level(input logic [7:0] o, oe, v, voe);
    return (oe & o) | (~oe & voe & v) | (~oe & ~voe);
  endfunction : level
  assign pinInB = level(pinOutB, pinOeB, extB, extOeB);
  assign pinInC = level(pinOutC, pinOeC, extC, extOeC);
  // D2 driven high by the far side puts the registers in standby
  assign pinInD = level({5'h0, pinOutD}, {5'h0, pinOeD},
    {5'h0, extD}, {5'h0, extOeD});
endmodule : mio_pin_model

// file: tb/mio_port_ctrl_test.sv
`timescale 1ns/1ps
module mio_port_ctrl_test;
  import mio_pkg::*;
  logic clk, reset_n, logicClock, memStandby;
  mio_bus_s bus;
  mio_cfg_s cfg;
  logic [7:0] rdData, mcFirst, mcShared, oeTermB, oeTermC, imcClkB, imcClkC;
  logic [7:0] ispOut, ispOe, extB, extOeB, extC, extOeC, pinInB, pinInC;
  logic [7:0] pinOutB, pinOeB, pinOutC, pinOeC, inMcB, inMcC;
  logic [3:0] slewFastB;
  logic [2:0] oeTermD, ecsTerm, extD, extOeD, pinInD, pinOutD, pinOeD;
  logic [2:0] slewFastD, arrayInD;
  int errors, n_checks;

  mio_port_ctrl i_mio_port_ctrl (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdData(rdData), .cfg(cfg), .macrocellGroupFirst(mcFirst),
    .macrocellGroupShared(mcShared), .oeTermB(oeTermB), .oeTermC(oeTermC),
    .oeTermD(oeTermD), .ecsTerm(ecsTerm), .imcClockTermB(imcClkB),
    .imcClockTermC(imcClkC), .ispOut(ispOut), .ispOe(ispOe),
    .pinInB(pinInB), .pinInC(pinInC), .pinInD(pinInD), .pinOutB(pinOutB),
    .pinOeB(pinOeB), .pinOutC(pinOutC), .pinOeC(pinOeC), .pinOutD(pinOutD),
    .pinOeD(pinOeD), .slewFastB(slewFastB), .slewFastD(slewFastD),
    .inputMacrocellB(inMcB), .inputMacrocellC(inMcC), .arrayInD(arrayInD),
    .logicClock(logicClock), .memStandby(memStandby));

  mio_pin_model i_mio_pin_model (.pinOutB(pinOutB), .pinOeB(pinOeB),
    .pinOutC(pinOutC), .pinOeC(pinOeC), .pinOutD(pinOutD), .pinOeD(pinOeD),
    .extB(extB), .extOeB(extOeB), .extC(extC), .extOeC(extOeC),
    .extD(extD), .extOeD(extOeD), .pinInB(pinInB), .pinInC(pinInC),
    .pinInD(pinInD));

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // A spare cycle after each access keeps strobes from toggling twice
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    bus.sel = sel;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(posedge clk);
    #1 bus.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] sel, input logic [7:0] exp);
    bus.sel = sel;
    bus.rd = 1'b1;
    @(posedge clk);
    #1 bus.rd = 1'b0;
    chk("rdData", exp, rdData);
    @(posedge clk);
    #1;
  endtask : rd

  // Pins are registered from registers, data-in from pins
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial begin
    {bus, cfg, mcFirst, mcShared, oeTermB, oeTermC, oeTermD, ecsTerm} = '0;
    {imcClkB, imcClkC, ispOut, ispOe, extB, extC, extD} = '0;
    {extOeB, extOeC, extOeD, errors, n_checks, reset_n} = '0;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("pinOeB", 8'h00, pinOeB);
    chk("pinOeC", 8'h00, pinOeC);
    chk("pinOeD", 8'h00, {5'h0, pinOeD});
    for (int i = 1; i < 12; i++) begin
      if (i % 4 != 0) rd(4'(i), REG_RESET);
    end
    for (int k = 0; k < 4; k++) begin
      oeTermB = {7'h0, k[1]};
      wr(REG_DIR_B, {7'h0, k[0]});
      settle();
      chk("pinOeB", {7'h0, k[0] | k[1]}, pinOeB);
    end
    oeTermB = 8'h00;
    wr(REG_DIR_D, 8'hFF);
    rd(REG_DIR_D, 8'h07);
    wr(REG_DIR_B, 8'hFF);
    wr(REG_DATAOUT_B, 8'hA5);
    settle();
    chk("pinOutB", 8'hA5, pinOutB);
    // Upper B pins from the array: 7,6 first group, 5,4 shared group
    {cfg.arrayDriveB, mcFirst, mcShared, cfg.portBGroupShared} =
      32'hF0A0_5030;
    wr(REG_DATAOUT_B, 8'h0F);
    settle();
    chk("pinOutB", 8'h9F, pinOutB);
    cfg.arrayDriveC = 8'hFF;
    wr(REG_DIR_C, 8'hFF);
    settle();
    chk("pinOutC", 8'h50, pinOutC);
    {cfg.arrayDriveB, cfg.arrayDriveC} = '0;
    wr(REG_DATAOUT_B, 8'h5A);
    wr(REG_DRV_B, 8'hF0);
    settle();
    chk("pinOeB", 8'hAF, pinOeB);
    chk("pinOutB", 8'h0A, pinOutB);
    chk("slewFastB", 8'h00, {4'h0, slewFastB});
    rd(REG_DATAIN_B, 8'h5A);
    wr(REG_DRV_B, 8'h0F);
    settle();
    chk("pinOeB", 8'hFF, pinOeB);
    chk("slewFastB", 8'h0F, {4'h0, slewFastB});
    wr(REG_DATAOUT_C, 8'h33);
    wr(REG_DRV_C, 8'hFF);
    settle();
    chk("pinOeC", 8'hCC, pinOeC);
    chk("pinOutC", 8'h00, pinOutC);
    wr(REG_DRV_D, 8'hFF);
    rd(REG_DRV_D, 8'h07);
    chk("slewFastD", 8'h07, {5'h0, slewFastD});
    {cfg.ecsEnable, cfg.ecsActiveHigh, ecsTerm} = 9'b111_101_011;
    settle();
    chk("pinOutD", 8'h01, {5'h0, pinOutD});
    oeTermD = 3'b010;
    wr(REG_DIR_D, 8'h00);
    settle();
    chk("pinOeD", 8'h02, {5'h0, pinOeD});
    {cfg.ecsEnable, oeTermD} = '0;
    wr(REG_DIR_B, 8'h00);
    wr(REG_DIR_C, 8'h00);
    wr(REG_DRV_C, 8'h00);
    {extB, extOeB, extD, extOeD} = {8'hC4, 8'hFF, 3'h6, 3'h7};
    settle();
    rd(REG_DATAIN_B, 8'hC4);
    chk("inMcB", 8'hC4, inMcB);
    chk("arrayInD", 8'h06, {5'h0, arrayInD});
    rd(REG_DATAIN_D, 8'h06);
    {cfg.imcRegisteredC, extC, extOeC, imcClkC} = 32'hFF11_FFFF;
    settle();
    {imcClkC, extC} = 16'h00EE;
    settle();
    chk("inMcC", 8'h11, inMcC);
    rd(REG_DATAIN_C, 8'hEE);
    {cfg.ispEnable, ispOut, ispOe, extOeC} = {1'b1, 8'h05, 8'h0F, 8'h00};
    settle();
    chk("pinOeC", 8'h0F, pinOeC);
    chk("pinOutC", 8'h05, {4'h0, pinOutC[3:0]});
    cfg.extClockEnable = 1'b1;
    extD = 3'b010;
    wr(REG_DIR_D, 8'h07);
    settle();
    chk("pinOeD", 8'h05, {5'h0, pinOeD});
    chk("logicClock", 8'h01, {7'h0, logicClock});
    {cfg.extClockEnable, cfg.chipSelInEnable, extD} = 5'b01_100;
    settle();
    chk("memStandby", 8'h01, {7'h0, memStandby});
    chk("pinOeD", 8'h03, {5'h0, pinOeD});
    wr(REG_DIR_B, 8'h77);
    extD = 3'b000;
    settle();
    chk("memStandby", 8'h00, {7'h0, memStandby});
    rd(REG_DIR_B, 8'h00);
    // Warm reset in mid-run must put every pin back to input
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("pinOeB", 8'h00, pinOeB);
    chk("pinOeC", 8'h00, pinOeC);
    chk("pinOeD", 8'h00, {5'h0, pinOeD});
    chk("slewFastB", 8'h00, {4'h0, slewFastB});
    rd(REG_DIR_D, 8'h00);
    rd(REG_DRV_B, 8'h00);
    rd(4'hF, UNMAPPED_READ);
    end_of_test();
  end
endmodule : mio_port_ctrl_test
